// ==== verilog/dtp_pkg.sv ====
// Purpose: constants and types of the down timer, pwm and buzzer block
// Assumes: clk is the instruction clock, axi4-lite register access
// Notes:
package dtp_pkg;
    localparam logic [5:0] OFF_CTRL1 = 6'h00;
    localparam logic [5:0] OFF_CTRL2 = 6'h04;
    localparam logic [5:0] OFF_COUNT = 6'h08;
    localparam logic [5:0] OFF_DUTY  = 6'h0C;
    localparam logic [5:0] OFF_BUZZ  = 6'h10;
    localparam logic [5:0] OFF_PSCV  = 6'h14;
    localparam logic [5:0] OFF_IFLAG = 6'h18;
    localparam logic [5:0] OFF_IEN   = 6'h1C;
    localparam logic [5:0] OFF_GIE   = 6'h20;
    localparam int C1_RUN    = 0;
    localparam int C1_RELOAD = 1;
    localparam int C1_ONE    = 2;
    localparam int C1_PWMLOW = 6;
    localparam int C1_PWMEN  = 7;
    localparam int C2_PSCN   = 3;
    localparam int C2_EDGE   = 4;
    localparam int C2_EXT    = 5;
    localparam int BZ_SRC    = 3;
    localparam int BZ_EN     = 7;
    localparam int IF_UF     = 3;
    localparam int GIE_BIT   = 0;
    localparam logic [7:0] RST_CTRL1 = 8'h00;
    localparam logic [7:0] RST_CTRL2 = 8'h08;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_DUTY  = 8'h00;
    localparam logic [7:0] RST_BUZZ  = 8'h00;
    localparam logic [7:0] FREE_TOP  = 8'hFF;
    localparam logic [1:0] RESP_OK   = 2'h0;
    localparam logic [1:0] RESP_ERR  = 2'h2;
    typedef struct packed {
        logic        awvalid;
        logic [5:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [5:0]  araddr;
        logic        rready;
    } dtp_axi_req_t;
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } dtp_axi_rsp_t;
    typedef struct packed {
        dtp_axi_rsp_t rsp;
        logic         awHeld;
        logic [5:0]   awAddr;
        logic         wHeld;
        logic [7:0]   wByte;
        logic         wLane;
        logic [7:0]   ctrl1;
        logic [7:0]   ctrl2;
        logic [7:0]   count;
        logic [7:0]   reload;
        logic [7:0]   duty;
        logic [7:0]   buzz;
        logic [7:0]   psc;
        logic [7:0]   bzCnt;
        logic         iflag;
        logic         ien;
        logic         global_irq_enable;
        logic         irq;
        logic         pwmOut;
        logic         pwmOe;
        logic         bzOut;
        logic         bzOe;
        logic         ext1;
        logic         ext2;
        logic         extPrev;
    } dtp_state_t;
endpackage

// ==== verilog/dtp_top.sv ====
// Purpose: down timer with prescaler, pwm and buzzer, axi4-lite slave
// Assumes: one clock, synchronous active high reset
// Notes: external count clock is sampled, so it must run below clk/4
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
module dtp_top
    import dtp_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire dtp_axi_req_t axiReq,
    output dtp_axi_rsp_t      axiRsp,
    input  wire logic         extClkPin,
    output logic              pwmPadOut,
    output logic              pwmPadOe,
    output logic              buzzerPadOut,
    output logic              buzzerPadOe,
    output logic              underflowIrq
);

    dtp_state_t s_q;
    dtp_state_t s_d;

    logic       srcTick;
    logic       pscTick;
    logic       tick;
    logic       uf;
    logic       bzEv;
    logic       commit;
    logic       wrCount;
    logic       wrCtrl1;
    logic       pwmAct;
    logic [7:0] rd;
    logic       rdOk;

    // mask of low bits for a 1:2 .. 1:256 divider
    function automatic logic [7:0] rateMask(input logic [2:0] sel);
        rateMask = 8'(({1'b0, 8'hFF} >> (3'h7 - sel)) & 9'h0FF);
    endfunction

    always_comb begin
        s_d     = s_q;
        rd      = 8'h00;
        rdOk    = 1'b1;
        wrCount = 1'b0;
        wrCtrl1 = 1'b0;
        uf      = 1'b0;
        pscTick = 1'b0;

        // two-stage sync, edges seen only behind the second stage
        s_d.ext1    = extClkPin;
        s_d.ext2    = s_q.ext1;
        s_d.extPrev = s_q.ext2;
        if (s_q.ctrl2[C2_EXT]) begin
            srcTick = s_q.ctrl2[C2_EDGE] ? (s_q.extPrev & ~s_q.ext2)
                                         : (s_q.ext2 & ~s_q.extPrev);
        end else begin
            srcTick = 1'b1;
        end

        // prescaler only advances while the timer runs
        if (s_q.ctrl1[C1_RUN] && srcTick && !s_q.ctrl2[C2_PSCN]) begin
            s_d.psc = s_q.psc + 8'h01;
            pscTick = (s_q.psc & rateMask(s_q.ctrl2[2:0])) ==
                      rateMask(s_q.ctrl2[2:0]);
        end
        tick = s_q.ctrl2[C2_PSCN] ? (s_q.ctrl1[C1_RUN] & srcTick) : pscTick;

        if (tick) begin
            if (s_q.count == 8'h00) begin
                uf = 1'b1;
                if (s_q.ctrl1[C1_ONE]) begin
                    s_d.ctrl1[C1_RUN] = 1'b0;
                end else begin
                    s_d.count = s_q.ctrl1[C1_RELOAD] ? s_q.reload
                                                     : FREE_TOP;
                end
            end else begin
                s_d.count = s_q.count - 8'h01;
            end
        end

        // pwm from the live count; duty 0 never matches
        pwmAct = (s_q.count != 8'h00) && (s_q.count <= s_q.duty);
        s_d.pwmOe  = s_q.ctrl1[C1_PWMEN];
        s_d.pwmOut = s_q.ctrl1[C1_PWMEN] & (pwmAct ^ s_q.ctrl1[C1_PWMLOW]);

        // buzzer divides count ticks (prescaler output, or source ticks when bypassed) or underflows
        bzEv = s_q.buzz[BZ_SRC] ? uf : tick;
        s_d.bzOe = s_q.buzz[BZ_EN];
        if (!s_q.buzz[BZ_EN]) begin
            s_d.bzCnt = 8'h00;
            s_d.bzOut = 1'b0;
        end else if (bzEv) begin
            s_d.bzCnt = s_q.bzCnt + 8'h01;
            if ((s_q.bzCnt & rateMask(s_q.buzz[2:0])) ==
                rateMask(s_q.buzz[2:0])) begin
                s_d.bzOut = ~s_q.bzOut;
            end
        end

        // write channel: address and data taken in either order
        if (axiReq.awvalid && s_q.rsp.awready) begin
            s_d.awHeld = 1'b1;
            s_d.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && s_q.rsp.wready) begin
            s_d.wHeld = 1'b1;
            s_d.wByte = axiReq.wdata[7:0];
            s_d.wLane = axiReq.wstrb[0];
        end
        if (s_q.rsp.bvalid && axiReq.bready) begin
            s_d.rsp.bvalid = 1'b0;
        end
        commit = s_q.awHeld && s_q.wHeld && !s_q.rsp.bvalid;
        if (commit) begin
            s_d.awHeld    = 1'b0;
            s_d.wHeld     = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp  = RESP_OK;
            unique case (s_q.awAddr)
                OFF_CTRL1: begin
                    wrCtrl1 = s_q.wLane;
                    if (s_q.wLane) s_d.ctrl1 = s_q.wByte;
                end
                OFF_CTRL2: begin
                    if (s_q.wLane) begin
                        s_d.ctrl2 = s_q.wByte;
                        s_d.psc   = 8'h00;
                    end
                end
                OFF_COUNT: begin
                    wrCount = s_q.wLane;
                    if (s_q.wLane) begin
                        s_d.count  = s_q.wByte;
                        s_d.reload = s_q.wByte;
                    end
                end
                OFF_DUTY: begin
                    if (s_q.wLane) s_d.duty = s_q.wByte;
                end
                OFF_BUZZ: begin
                    if (s_q.wLane) s_d.buzz = s_q.wByte;
                end
                OFF_PSCV: begin
                end
                OFF_IFLAG: begin
                    if (s_q.wLane) s_d.iflag = s_q.iflag & s_q.wByte[IF_UF];
                end
                OFF_IEN: begin
                    if (s_q.wLane) s_d.ien = s_q.wByte[IF_UF];
                end
                OFF_GIE: begin
                    if (s_q.wLane) s_d.global_irq_enable = s_q.wByte[GIE_BIT];
                end
                default: begin
                    s_d.rsp.bresp = RESP_ERR;
                end
            endcase
        end
        s_d.rsp.awready = !s_d.awHeld && !s_d.rsp.bvalid;
        s_d.rsp.wready  = !s_d.wHeld && !s_d.rsp.bvalid;

        // an underflow in the clearing cycle keeps the flag
        if (uf) begin
            s_d.iflag = 1'b1;
        end
        s_d.irq = s_d.iflag & s_d.ien & s_d.global_irq_enable;

        // read channel, answer one cycle after address
        unique case (axiReq.araddr)
            OFF_CTRL1: rd = s_q.ctrl1;
            OFF_CTRL2: rd = s_q.ctrl2;
            OFF_COUNT: rd = s_q.count;
            OFF_DUTY:  rd = s_q.duty;
            OFF_BUZZ:  rd = s_q.buzz;
            OFF_PSCV:  rd = s_q.psc;
            OFF_IFLAG: rd = {4'h0, s_q.iflag, 3'h0};
            OFF_IEN:   rd = {4'h0, s_q.ien, 3'h0};
            OFF_GIE:   rd = {7'h00, s_q.global_irq_enable};
            default:   rdOk = 1'b0;
        endcase
        if (s_q.rsp.rvalid && axiReq.rready) begin
            s_d.rsp.rvalid = 1'b0;
        end
        if (axiReq.arvalid && s_q.rsp.arready) begin
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rdata  = {24'h000000, rd};
            s_d.rsp.rresp  = rdOk ? RESP_OK : RESP_ERR;
        end
        s_d.rsp.arready = !s_d.rsp.rvalid;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q             <= '0;
            s_q.ctrl1       <= RST_CTRL1;
            s_q.ctrl2       <= RST_CTRL2;
            s_q.count       <= RST_COUNT;
            s_q.reload      <= RST_COUNT;
            s_q.duty        <= RST_DUTY;
            s_q.buzz        <= RST_BUZZ;
            s_q.rsp.bresp   <= RESP_OK;
            s_q.rsp.rresp   <= RESP_OK;
        end else begin
            s_q <= s_d;
        end
    end

    assign axiRsp       = s_q.rsp;
    assign pwmPadOut    = s_q.pwmOut;
    assign pwmPadOe     = s_q.pwmOe;
    assign buzzerPadOut = s_q.bzOut;
    assign buzzerPadOe  = s_q.bzOe;
    assign underflowIrq = s_q.irq;

    property p_load;
        @(posedge clk) disable iff (sys_rst)
        wrCount |=> (s_q.count == $past(s_q.wByte)) && (s_q.reload == s_q.count);
    endproperty
    a_load: assert property (p_load) else $error("count write not loaded");

    property p_read;
        @(posedge clk) disable iff (sys_rst)
        (axiReq.arvalid && s_q.rsp.arready && axiReq.araddr == OFF_COUNT)
        |=> s_q.rsp.rvalid && s_q.rsp.rdata[7:0] == $past(s_q.count);
    endproperty
    a_read: assert property (p_read) else $error("count read not live");

    property p_stop;
        @(posedge clk) disable iff (sys_rst)
        (!s_q.ctrl1[C1_RUN] && !wrCount) |=> $stable(s_q.count);
    endproperty
    a_stop: assert property (p_stop) else $error("count moved while stopped");

    property p_dec;
        @(posedge clk) disable iff (sys_rst)
        (tick && s_q.count != 8'h00 && !wrCount)
        |=> s_q.count == $past(s_q.count) - 8'h01;
    endproperty
    a_dec: assert property (p_dec) else $error("count did not decrement");

    property p_psc;
        @(posedge clk) disable iff (sys_rst)
        (tick && !s_q.ctrl2[C2_PSCN])
        |-> (s_q.psc & rateMask(s_q.ctrl2[2:0])) == rateMask(s_q.ctrl2[2:0]);
    endproperty
    a_psc: assert property (p_psc) else $error("prescaler tick misplaced");

    property p_one;
        @(posedge clk) disable iff (sys_rst)
        (uf && s_q.ctrl1[C1_ONE] && !wrCtrl1 && !wrCount)
        |=> !s_q.ctrl1[C1_RUN] ##1 s_q.count == 8'h00;
    endproperty
    a_one: assert property (p_one) else $error("one-shot did not stop");

    property p_free;
        @(posedge clk) disable iff (sys_rst)
        (uf && !s_q.ctrl1[C1_ONE] && !wrCount)
        |=> s_q.count == ($past(s_q.ctrl1[C1_RELOAD]) ? $past(s_q.reload) : FREE_TOP);
    endproperty
    a_free: assert property (p_free) else $error("free run restart wrong");

    property p_flag;
        @(posedge clk) disable iff (sys_rst)
        uf |=> s_q.iflag;
    endproperty
    a_flag: assert property (p_flag) else $error("underflow flag not set");

    property p_irq;
        @(posedge clk) disable iff (sys_rst)
        underflowIrq |-> s_q.global_irq_enable && s_q.ien && s_q.iflag;
    endproperty
    a_irq: assert property (p_irq) else $error("irq without its enables");

    property p_pwm0;
        @(posedge clk) disable iff (sys_rst)
        (s_q.duty == 8'h00 && s_q.ctrl1[C1_PWMEN] && !s_q.ctrl1[C1_PWMLOW])
        |=> pwmPadOe && !pwmPadOut;
    endproperty
    a_pwm0: assert property (p_pwm0) else $error("pwm active at zero duty");

    property p_bz;
        @(posedge clk) disable iff (sys_rst)
        (s_q.buzz[BZ_EN] && !bzEv) |=> $stable(buzzerPadOut) && buzzerPadOe;
    endproperty
    a_bz: assert property (p_bz) else $error("buzzer toggled without tick");

    // pin mode: only a synchronised edge of the chosen kind moves the count
    property p_noedge;
        @(posedge clk) disable iff (sys_rst)
        (s_q.ctrl2[C2_EXT] && s_q.ctrl2[C2_PSCN] && !wrCount &&
         (s_q.ext2 == s_q.extPrev || s_q.ext2 == s_q.ctrl2[C2_EDGE]))
        |=> $stable(s_q.count);
    endproperty
    a_noedge: assert property (p_noedge) else $error("count moved without pin edge");

    property p_edge;
        @(posedge clk) disable iff (sys_rst)
        (s_q.ctrl1[C1_RUN] && s_q.ctrl2[C2_EXT] && s_q.ctrl2[C2_PSCN] && !wrCount &&
         s_q.count != 8'h00 && s_q.ext2 != s_q.extPrev && (s_q.ext2 ^ s_q.ctrl2[C2_EDGE]))
        |=> s_q.count == $past(s_q.count) - 8'h01;
    endproperty
    a_edge: assert property (p_edge) else $error("chosen pin edge not counted");

    property p_pscoff;
        @(posedge clk) disable iff (sys_rst)
        (s_q.ctrl2[C2_PSCN] && !commit) |=> $stable(s_q.psc);
    endproperty
    a_pscoff: assert property (p_pscoff) else $error("prescaler moved while off");

    property p_pscv;
        @(posedge clk) disable iff (sys_rst)
        (axiReq.arvalid && s_q.rsp.arready && axiReq.araddr == OFF_PSCV)
        |=> s_q.rsp.rvalid && s_q.rsp.rdata[7:0] == $past(s_q.psc);
    endproperty
    a_pscv: assert property (p_pscv) else $error("prescaler value not readable");

    property p_pwmoff;
        @(posedge clk) disable iff (sys_rst)
        !s_q.ctrl1[C1_PWMEN] |=> !pwmPadOe && !pwmPadOut;
    endproperty
    a_pwmoff: assert property (p_pwmoff) else $error("pwm pad driven while off");

    property p_pwmidle;
        @(posedge clk) disable iff (sys_rst)
        (s_q.ctrl1[C1_PWMEN] && s_q.count > s_q.duty)
        |=> pwmPadOe && (pwmPadOut == $past(s_q.ctrl1[C1_PWMLOW]));
    endproperty
    a_pwmidle: assert property (p_pwmidle) else $error("pwm active above duty");

    property p_bzoff;
        @(posedge clk) disable iff (sys_rst)
        !s_q.buzz[BZ_EN] |=> !buzzerPadOe && !buzzerPadOut;
    endproperty
    a_bzoff: assert property (p_bzoff) else $error("buzzer pad driven while off");

    property p_bzsrc;
        @(posedge clk) disable iff (sys_rst)
        (s_q.buzz[BZ_EN] && s_q.buzz[BZ_SRC] && !uf) |=> $stable(buzzerPadOut);
    endproperty
    a_bzsrc: assert property (p_bzsrc) else $error("buzzer moved without underflow");

    c_one:  cover property (@(posedge clk) disable iff (sys_rst) uf && s_q.ctrl1[C1_ONE]);
    c_free: cover property (@(posedge clk) disable iff (sys_rst) uf && s_q.ctrl1[C1_RELOAD]);
    c_irq:  cover property (@(posedge clk) disable iff (sys_rst) $rose(underflowIrq));
    c_bz:   cover property (@(posedge clk) disable iff (sys_rst) $rose(buzzerPadOut));
    c_ext:  cover property (@(posedge clk) disable iff (sys_rst) tick && s_q.ctrl2[C2_EXT]);

endmodule

// ==== tb/dtp_pad_model.sv ====
// Purpose: far side of the timer block: external count clock and the two pads
// Assumes: pads are sampled on the falling clock edge, away from the bench's edge
// Notes: the count clock stands still between bursts
`timescale 1ns/10ps
module dtp_pad_model (
    input  wire logic clk,
    input  wire logic pwmPadOut,
    input  wire logic pwmPadOe,
    input  wire logic buzzerPadOut,
    input  wire logic buzzerPadOe,
    output logic      extClkPin
);
    int   pwmHigh;
    int   bzToggles;
    logic bzPrev;

    initial begin
        extClkPin = 1'b0;
        pwmHigh   = 0;
        bzToggles = 0;
        bzPrev    = 1'b0;
    end

    // running totals; the bench takes differences, so no clear is needed
    always @(negedge clk) begin
        if (pwmPadOe === 1'b1 && pwmPadOut === 1'b1) begin
            pwmHigh++;
        end
        if (buzzerPadOe === 1'b1 && buzzerPadOut !== bzPrev) begin
            bzToggles++;
        end
        bzPrev = buzzerPadOut;
    end

    // half period of 4 clocks keeps the pin below the sampler's limit
    task automatic burst(input int n, input bit endHigh);
        repeat (n) begin
            repeat (4) @(posedge clk);
            extClkPin <= 1'b1;
            repeat (4) @(posedge clk);
            extClkPin <= 1'b0;
        end
        if (endHigh) begin
            repeat (4) @(posedge clk);
            extClkPin <= 1'b1;
        end
        repeat (8) @(posedge clk);
    endtask

    task automatic idle();
        extClkPin <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
endmodule

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench of the down timer, pwm and buzzer block
// Assumes: axi4-lite master tasks, all bench edges on the rising clock
// Notes: pad activity is counted by the pad model on the falling edge
`timescale 1ns/10ps
module tb_top
    import dtp_pkg::*;
;
    logic         clk;
    logic         sysRst;
    dtp_axi_req_t axiReq;
    dtp_axi_rsp_t axiRsp;
    logic         extClkPin;
    logic         pwmPadOut;
    logic         pwmPadOe;
    logic         buzzerPadOut;
    logic         buzzerPadOe;
    logic         underflowIrq;
    int           num_errors  = 0;
    int           check_count = 0;
    int           cyc         = 0;
    int           n0;
    logic [31:0]  rd;
    logic [1:0]   rs;

    dtp_top dut (
        .clk          (clk),
        .sys_rst      (sysRst),
        .axiReq       (axiReq),
        .axiRsp       (axiRsp),
        .extClkPin    (extClkPin),
        .pwmPadOut    (pwmPadOut),
        .pwmPadOe     (pwmPadOe),
        .buzzerPadOut (buzzerPadOut),
        .buzzerPadOe  (buzzerPadOe),
        .underflowIrq (underflowIrq)
    );

    dtp_pad_model pads (
        .clk          (clk),
        .pwmPadOut    (pwmPadOut),
        .pwmPadOe     (pwmPadOe),
        .buzzerPadOut (buzzerPadOut),
        .buzzerPadOe  (buzzerPadOe),
        .extClkPin    (extClkPin)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // the limit is well above the roughly 36k cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_range(input logic [31:0] got, input logic [31:0] lo,
                               input logic [31:0] hi);
        check_count++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // entered just after a rising edge; response code left in rs
    task automatic axi_wr(input logic [5:0] a, input logic [7:0] d);
        bit awDone;
        bit wDone;
        awDone = 1'b0;
        wDone  = 1'b0;
        axiReq.awvalid <= 1'b1;
        axiReq.awaddr  <= a;
        axiReq.wvalid  <= 1'b1;
        axiReq.wdata   <= {24'h000000, d};
        axiReq.wstrb   <= 4'hF;
        while (!(awDone && wDone)) begin
            @(posedge clk);
            if (!awDone && axiRsp.awready === 1'b1) begin
                awDone = 1'b1;
                axiReq.awvalid <= 1'b0;
            end
            if (!wDone && axiRsp.wready === 1'b1) begin
                wDone = 1'b1;
                axiReq.wvalid <= 1'b0;
            end
        end
        axiReq.bready <= 1'b1;
        do @(posedge clk); while (axiRsp.bvalid !== 1'b1);
        rs = axiRsp.bresp;
        axiReq.bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        axiReq.arvalid <= 1'b1;
        axiReq.araddr  <= a;
        do @(posedge clk); while (axiRsp.arready !== 1'b1);
        axiReq.arvalid <= 1'b0;
        axiReq.rready  <= 1'b1;
        do @(posedge clk); while (axiRsp.rvalid !== 1'b1);
        d = axiRsp.rdata;
        r = axiRsp.rresp;
        axiReq.rready <= 1'b0;
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        check_val(d, exp);
    endtask

    task automatic t_reset();
        check_val({pwmPadOe, buzzerPadOe, underflowIrq}, 3'b000);
        rd_chk(OFF_CTRL2, 32'h08);
        rd_chk(OFF_COUNT, 32'h00);
        axi_rd(6'h24, rd, rs);
        check_val(rs, RESP_ERR);
        axi_wr(6'h24, 8'hFF);
        check_val(rs, RESP_ERR);
        axi_wr(OFF_COUNT, 8'h5A);
        rd_chk(OFF_COUNT, 32'h5A);
        $display("test reset done");
    endtask

    task automatic t_irq();
        axi_wr(OFF_IEN, 8'h08);
        axi_wr(OFF_GIE, 8'h01);
        axi_wr(OFF_COUNT, 8'h03);
        axi_wr(OFF_CTRL1, 8'h03);
        wait_clk(12);
        check_val(underflowIrq, 1'b1);
        axi_wr(OFF_CTRL1, 8'h00);
        axi_rd(OFF_COUNT, rd, rs);
        check_range(rd, 32'h00, 32'h03);
        wait_clk(20);
        rd_chk(OFF_COUNT, rd);
        rd_chk(OFF_IFLAG, 32'h08);
        axi_wr(OFF_GIE, 8'h00);
        wait_clk(1);
        check_val(underflowIrq, 1'b0);
        axi_wr(OFF_IFLAG, 8'h08);
        rd_chk(OFF_IFLAG, 32'h08);
        axi_wr(OFF_IFLAG, 8'h00);
        rd_chk(OFF_IFLAG, 32'h00);
        $display("test irq done");
    endtask

    task automatic t_oneshot();
        axi_wr(OFF_COUNT, 8'h02);
        axi_wr(OFF_CTRL1, 8'h05);
        wait_clk(12);
        rd_chk(OFF_CTRL1, 32'h04);
        rd_chk(OFF_COUNT, 32'h00);
        rd_chk(OFF_IFLAG, 32'h08);
        axi_wr(OFF_IFLAG, 8'h00);
        // free run without reload wraps to FF, far from the loaded 01
        axi_wr(OFF_COUNT, 8'h01);
        axi_wr(OFF_CTRL1, 8'h01);
        wait_clk(8);
        axi_wr(OFF_CTRL1, 8'h00);
        axi_rd(OFF_COUNT, rd, rs);
        check_range(rd, 32'hF0, 32'hFA);
        axi_wr(OFF_IFLAG, 8'h00);
        $display("test oneshot done");
    endtask

    // four rising and three falling edges tell the edge choice apart
    task automatic t_ext();
        for (int e = 0; e < 2; e++) begin
            axi_wr(OFF_CTRL2, (e == 1) ? 8'h38 : 8'h28);
            axi_wr(OFF_COUNT, 8'h0A);
            axi_wr(OFF_CTRL1, 8'h01);
            pads.burst(3, 1'b1);
            axi_wr(OFF_CTRL1, 8'h00);
            rd_chk(OFF_COUNT, (e == 1) ? 32'h07 : 32'h06);
            pads.idle();
        end
        $display("test ext clock done");
    endtask

    // the window gives 32 prescaled ticks at every rate; edges of it cost a tick or two
    task automatic t_psc();
        for (int c = 0; c < 8; c++) begin
            axi_wr(OFF_CTRL2, 8'(c));
            axi_wr(OFF_COUNT, 8'hFF);
            axi_wr(OFF_CTRL1, 8'h01);
            wait_clk(64 << c);
            axi_wr(OFF_CTRL1, 8'h00);
            axi_rd(OFF_COUNT, rd, rs);
            check_range(rd, 32'hDD, 32'hE1);
            axi_rd(OFF_PSCV, rd, rs);
            check_val(rs, RESP_OK);
            check_range(rd, ((64 << c) + 1) & 32'hFF, ((64 << c) + 5) & 32'hFF);
        end
        $display("test prescaler done");
    endtask

    task automatic t_pwm();
        logic [7:0] pw [4][3] = '{'{8'h07, 8'h83, 8'h03}, '{8'h07, 8'hC3, 8'h03},
                                 '{8'h07, 8'h83, 8'h00}, '{8'hFF, 8'h83, 8'hFF}};
        int exp;
        axi_wr(OFF_CTRL2, 8'h08);
        for (int i = 0; i < 4; i++) begin
            axi_wr(OFF_CTRL1, 8'h00);
            axi_wr(OFF_COUNT, pw[i][0]);
            axi_wr(OFF_DUTY, pw[i][2]);
            axi_wr(OFF_CTRL1, pw[i][1]);
            wait_clk(8);
            n0 = pads.pwmHigh;
            wait_clk(8 * (pw[i][0] + 1));
            exp = pw[i][1][6] ? 8 * (pw[i][0] + 1 - pw[i][2]) : 8 * pw[i][2];
            check_val(pwmPadOe, 1'b1);
            check_val(pads.pwmHigh - n0, exp);
        end
        axi_wr(OFF_CTRL1, 8'h00);
        wait_clk(2);
        check_val({pwmPadOe, pwmPadOut}, 2'b00);
        $display("test pwm done");
    endtask

    // window holds sixteen toggle periods at every rate of the tick source, and at 1:2 for the underflow source
    task automatic t_buzz();
        // prescaler on at 1:2 so the buzzer really divides its output
        axi_wr(OFF_CTRL2, 8'h00);
        axi_wr(OFF_COUNT, 8'h01);
        axi_wr(OFF_CTRL1, 8'h03);
        for (int c = 0; c < 9; c++) begin
            axi_wr(OFF_BUZZ, (c < 8) ? (8'h80 | 8'(c)) : 8'h88);
            wait_clk(8);
            n0 = pads.bzToggles;
            wait_clk((c < 8) ? (64 << c) : 128);
            check_val(buzzerPadOe, 1'b1);
            check_val(pads.bzToggles - n0, 16);
        end
        axi_wr(OFF_CTRL1, 8'h00);
        axi_wr(OFF_BUZZ, 8'h00);
        wait_clk(2);
        check_val(buzzerPadOe, 1'b0);
        $display("test buzzer done");
    endtask

    initial begin
        axiReq = '0;
        sysRst = 1'b1;
        repeat (6) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_irq();
        t_oneshot();
        t_ext();
        t_psc();
        t_pwm();
        t_buzz();
        print_verdict();
    end
endmodule
